// ---- abu_map.svh ----
// Purpose: register offsets, field positions, reset values and vectors of the breakpoint unit
// Assumes: 8-bit register port with a 3-bit address
// Notes: offsets are local to the unit
`ifndef ABU_MAP_SVH
`define ABU_MAP_SVH
`define ABU_OFF_CTRL 3'h0
`define ABU_OFF_ADDR_HI 3'h1
`define ABU_OFF_ADDR_LO 3'h2
`define ABU_OFF_WAIT_STAT 3'h3
`define ABU_OFF_FLAG_CTRL 3'h4
`define ABU_OFF_IRQ_STAT 3'h5
`define ABU_OFF_IRQ_MASK 3'h6
`define ABU_BIT_ENABLE 7
`define ABU_BIT_ACTIVE 6
`define ABU_BIT_WAIT_EXIT 1
`define ABU_BIT_CLR_FLAGS 7
`define ABU_BIT_EV_MATCH 0
`define ABU_BIT_EV_SOFT 1
`define ABU_RST_BYTE 8'h00
`define ABU_SWI_OPCODE 8'h83
`define ABU_VEC_NORMAL 16'hFFFC
`define ABU_VEC_MONITOR 16'hFEFC
`endif

// ---- abu_pkg.sv ----
// Purpose: types of the breakpoint unit
// Assumes: nothing
// Notes: the cpu-side request travels as one struct
package abu_pkg;
   typedef enum logic [1:0] {ABU_IDLE, ABU_PEND, ABU_BREAK} abu_state_e;
   typedef struct packed
   {
      logic request;
      logic [7:0] opcode;
      logic [15:0] vector;
   } abu_break_s;
endpackage

// ---- abu_address_breakpoint_unit.sv ----
// Purpose: address breakpoint unit: match, soft break, break state and side effects
// Assumes: cpu gives program address, opcode-fetch and instruction-boundary strobes
// Notes: registers on an 8-bit port; read data one cycle after the read strobe
//
// Design decisions made here: strobed register access and the placing of the registers.
`include "abu_map.svh"

// Summary of operation
// - request a break when the program address equals the break address
// - on a break, supply the software interrupt opcode to the instruction register
// - vector to FFFC, or to FEFC in monitor mode
// - a match sets the active flag; software writing one starts a break
// - a soft break is taken just before the next instruction starts
// - a break on an opcode address stops that instruction running
// - a break on an operand address lets the instruction finish first
// - return-from-interrupt in the handler ends the break state
// - cleared flag with unchanged address gives no further break after exit
// - enable bit 7 gates matches; write zero or reset clears it
// - address high and low bytes hold the break address, reset to zero
// - during a break, halt the timer and block input captures
// - during a break, stop the watchdog while the test voltage is present
// - other status bits are clearable in break only with clear-enable set
// - wait-exit bit set when a break ended wait mode, else cleared
// - in wait and stop the unit stays on but never matches
module abu_address_breakpoint_unit
   import abu_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rst_b,
   input wire logic [2:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic [15:0] i_cpu_addr,
   input wire logic i_opcode_fetch,
   input wire logic i_instr_start,
   input wire logic i_operand_fetch,
   input wire logic i_instr_end,
   input wire logic i_rti_exec,
   input wire logic i_monitor_mode,
   input wire logic i_wait_mode,
   input wire logic i_stop_mode,
   input wire logic i_high_test_voltage,
   output logic [7:0] o_rdata,
   output abu_break_s o_break,
   output logic o_break_state,
   output logic o_timer_halt,
   output logic o_capture_block,
   output logic o_watchdog_stop,
   output logic o_status_clear_ok,
   output logic o_wait_exited_by_break,
   output logic o_irq
);
   // ----------------------------------------------------------------
   // register port decode
   // ----------------------------------------------------------------
   logic enable_q;
   logic active_q;
   logic [7:0] addr_hi_q;
   logic [7:0] addr_lo_q;
   logic clr_flags_q;
   logic wait_exit_q;
   logic [1:0] irq_stat_q;
   logic [1:0] irq_mask_q;
   logic [7:0] rdata_d;
   abu_state_e state_q;
   logic operand_hit_q;
   logic hold_q;

   wire wr_ctrl = i_wr && (i_addr == `ABU_OFF_CTRL);
   wire wr_hi = i_wr && (i_addr == `ABU_OFF_ADDR_HI);
   wire wr_lo = i_wr && (i_addr == `ABU_OFF_ADDR_LO);
   wire wr_flag = i_wr && (i_addr == `ABU_OFF_FLAG_CTRL);
   wire wr_mask = i_wr && (i_addr == `ABU_OFF_IRQ_MASK);
   wire rd_stat = i_rd && (i_addr == `ABU_OFF_IRQ_STAT);
   wire soft_break = wr_ctrl && i_wdata[`ABU_BIT_ACTIVE];
   wire [15:0] brk_addr = {addr_hi_q, addr_lo_q};
   wire low_power = i_wait_mode || i_stop_mode;

   // ----------------------------------------------------------------
   // address compare
   // ----------------------------------------------------------------
   // the already-active flag masks a repeat match until software re-arms
   wire addr_eq = (i_cpu_addr == brk_addr) && !low_power;
   wire match_ok = enable_q && addr_eq && !active_q && !hold_q;
   wire opcode_hit = match_ok && i_opcode_fetch;
   wire operand_hit = match_ok && i_operand_fetch;
   wire take_now = opcode_hit
      || ((operand_hit_q || state_q == ABU_PEND) && i_instr_start);
   wire hw_set = opcode_hit || operand_hit;

   // a matched address stays spent until software loads a new break address
   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
         hold_q <= 1'b0;
      else if (hw_set)
         hold_q <= 1'b1;
      else if (wr_hi || wr_lo)
         hold_q <= 1'b0;
   end

   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
         operand_hit_q <= 1'b0;
      else if (operand_hit)
         operand_hit_q <= 1'b1;
      else if (i_instr_start)
         operand_hit_q <= 1'b0;
   end

   // ----------------------------------------------------------------
   // break sequencing
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
         state_q <= ABU_IDLE;
      else
         unique case (state_q)
            ABU_IDLE:
               if (take_now)
                  state_q <= ABU_BREAK;
               else if (soft_break)
                  state_q <= ABU_PEND;
            ABU_PEND:
               if (i_instr_start)
                  state_q <= ABU_BREAK;
            ABU_BREAK:
               if (i_rti_exec)
                  state_q <= ABU_IDLE;
         endcase
   end

   // ----------------------------------------------------------------
   // control registers
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         enable_q <= 1'b0;
         active_q <= 1'b0;
         addr_hi_q <= `ABU_RST_BYTE;
         addr_lo_q <= `ABU_RST_BYTE;
         clr_flags_q <= 1'b0;
      end
      else
      begin
         if (wr_ctrl)
            enable_q <= i_wdata[`ABU_BIT_ENABLE];
         if (hw_set || soft_break)
            active_q <= 1'b1;
         else if (wr_ctrl)
            active_q <= 1'b0;
         if (wr_hi)
            addr_hi_q <= i_wdata;
         if (wr_lo)
            addr_lo_q <= i_wdata;
         if (wr_flag)
            clr_flags_q <= i_wdata[`ABU_BIT_CLR_FLAGS];
      end
   end

   // wait exit indication updates on each break entry
   wire break_entry = take_now && state_q != ABU_BREAK;
   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
         wait_exit_q <= 1'b0;
      else if (break_entry)
         wait_exit_q <= i_wait_mode;
   end

   // ----------------------------------------------------------------
   // interrupt status and mask
   // ----------------------------------------------------------------
   wire [1:0] ev = {soft_break, hw_set};
   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         irq_stat_q <= 2'h0;
         irq_mask_q <= 2'h0;
      end
      else
      begin
         irq_stat_q <= (rd_stat ? 2'h0 : irq_stat_q) | ev;
         if (wr_mask)
            irq_mask_q <= i_wdata[1:0];
      end
   end

   // ----------------------------------------------------------------
   // read mux and outputs
   // ----------------------------------------------------------------
   always_comb
   begin
      rdata_d = 8'h00;
      if (i_rd)
         unique case (i_addr)
            `ABU_OFF_CTRL: rdata_d = {enable_q, active_q, 6'h00};
            `ABU_OFF_ADDR_HI: rdata_d = addr_hi_q;
            `ABU_OFF_ADDR_LO: rdata_d = addr_lo_q;
            `ABU_OFF_WAIT_STAT: rdata_d = {6'h00, wait_exit_q, 1'b0};
            `ABU_OFF_FLAG_CTRL: rdata_d = {clr_flags_q, 7'h00};
            `ABU_OFF_IRQ_STAT: rdata_d = {6'h00, irq_stat_q};
            `ABU_OFF_IRQ_MASK: rdata_d = {6'h00, irq_mask_q};
            default: rdata_d = 8'h00;
         endcase
   end

   wire in_break_d = (state_q == ABU_BREAK && !i_rti_exec) || take_now;
   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         o_rdata <= 8'h00;
         o_break <= '0;
         o_break_state <= 1'b0;
         o_timer_halt <= 1'b0;
         o_capture_block <= 1'b0;
         o_watchdog_stop <= 1'b0;
         o_status_clear_ok <= 1'b1;
         o_wait_exited_by_break <= 1'b0;
         o_irq <= 1'b0;
      end
      else
      begin
         o_rdata <= rdata_d;
         o_break.request <= take_now;
         o_break.opcode <= `ABU_SWI_OPCODE;
         o_break.vector <= i_monitor_mode ? `ABU_VEC_MONITOR : `ABU_VEC_NORMAL;
         o_break_state <= in_break_d;
         o_timer_halt <= in_break_d;
         o_capture_block <= in_break_d;
         o_watchdog_stop <= in_break_d && i_high_test_voltage;
         o_status_clear_ok <= !in_break_d || clr_flags_q;
         o_wait_exited_by_break <= wait_exit_q;
         o_irq <= |(((rd_stat ? 2'h0 : irq_stat_q) | ev) & irq_mask_q);
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   chk_match_request: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      opcode_hit |=> o_break.request)
      else $error("opcode match gave no break request");
   chk_swi_opcode: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      o_break.request |-> o_break.opcode == `ABU_SWI_OPCODE)
      else $error("break opcode wrong");
   chk_vector_sel: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      i_monitor_mode |=> o_break.vector == `ABU_VEC_MONITOR)
      else $error("monitor vector wrong");
   chk_flag_set: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      (hw_set || soft_break) |=> active_q)
      else $error("active flag not set");
   chk_soft_break: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      (state_q == ABU_PEND && i_instr_start) |=> o_break.request)
      else $error("soft break not taken at instruction start");
   chk_rti_exit: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      (state_q == ABU_BREAK && i_rti_exec) |=> !o_break_state)
      else $error("return did not end break");
   chk_enable_gate: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      !enable_q |-> !hw_set)
      else $error("match while disabled");
   chk_timer_halt: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      o_break_state |-> o_timer_halt && o_capture_block)
      else $error("timer not halted in break");
   chk_watchdog: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      (in_break_d && i_high_test_voltage) |=> o_watchdog_stop)
      else $error("watchdog not stopped");
   chk_no_lowpower: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      low_power |-> !hw_set)
      else $error("match in low power");
   chk_no_rebreak: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      hold_q |-> !hw_set)
      else $error("repeat match on unchanged address");
   chk_operand_defer: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      (operand_hit && !i_opcode_fetch && !i_instr_start && state_q != ABU_PEND
      && !operand_hit_q) |=> !o_break.request)
      else $error("operand break taken before instruction end");
   chk_wait_exit: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      break_entry |=> wait_exit_q == $past(i_wait_mode))
      else $error("wait exit bit wrong");
   chk_clear_gate: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      (in_break_d && !clr_flags_q) |=> !o_status_clear_ok)
      else $error("status clear allowed in break");
   chk_active_clear: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      (wr_ctrl && !i_wdata[`ABU_BIT_ACTIVE] && !hw_set) |=> !active_q)
      else $error("active flag not cleared by write of zero");
   cov_opcode_break: cover property (@(posedge i_clk) disable iff (!i_rst_b) opcode_hit);
   cov_operand_break: cover property (@(posedge i_clk) disable iff (!i_rst_b)
      operand_hit ##[1:20] o_break.request);
   cov_soft_break: cover property (@(posedge i_clk) disable iff (!i_rst_b)
      soft_break ##[1:20] o_break.request);
   cov_rti: cover property (@(posedge i_clk) disable iff (!i_rst_b)
      o_break_state ##[1:50] !o_break_state);
endmodule

// ---- abu_cpu_model.sv ----
// Purpose: cpu and integration side model, fetches one instruction per go pulse
// Assumes: opcode at the base address, one operand after it, then a boundary
// Notes: while idle the address shows the inverse of the base, never a stale match
module abu_cpu_model
(
   input wire logic i_clk,
   input wire logic i_go,
   input wire logic [15:0] i_base,
   output logic [15:0] o_cpu_addr,
   output logic o_opcode_fetch,
   output logic o_operand_fetch,
   output logic o_instr_start
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] step_q = 2'h0;
   always @(posedge i_clk)
   begin
      step_q <= i_go ? 2'h1 : ((step_q == 2'h0) ? 2'h0 : step_q + 2'h1);
   end
   assign o_opcode_fetch = (step_q == 2'h1);
   assign o_operand_fetch = (step_q == 2'h2);
   assign o_instr_start = (step_q == 2'h3);
   assign o_cpu_addr = o_opcode_fetch ? i_base : (o_operand_fetch ? i_base + 16'h1 : ~i_base);
endmodule

// ---- tb_top.sv ----
// Purpose: self-checking bench of the address breakpoint unit
// Assumes: register map and break timing as handed over
// Notes: the stop-mode and end-of-instruction inputs are tied low
`include "abu_map.svh"
module tb_top;
   import abu_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic i_clk = 1'b0;
   logic i_rst_b = 1'b0;
   logic [2:0] addr = 3'h0;
   logic [7:0] wdata = 8'h00;
   logic wr = 1'b0, rd = 1'b0, go = 1'b0, return_from_interrupt_op = 1'b0, mon = 1'b0, wait_m = 1'b0, htv = 1'b0;
   logic [15:0] base = 16'h0000;
   logic [15:0] cpu_addr;
   logic opf, operf, istart, bstate, thalt, cblock, wdstop, clr_ok, wexit, irq, irq_a;
   logic [7:0] rdata, d;
   abu_break_s brk, last_brk;
   int errors = 0;
   int check_count = 0;
   int reqs = 0;
   initial forever #4 i_clk = ~i_clk;
   always @(posedge i_clk)
   begin
      if (brk.request === 1'b1)
      begin
         reqs <= reqs + 1;
         last_brk <= brk;
      end
   end
   abu_cpu_model abu_cpu_model_i (.i_clk(i_clk), .i_go(go), .i_base(base),
      .o_cpu_addr(cpu_addr), .o_opcode_fetch(opf), .o_operand_fetch(operf),
      .o_instr_start(istart));
   abu_address_breakpoint_unit abu_address_breakpoint_unit_i (.i_clk(i_clk),
      .i_rst_b(i_rst_b), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
      .i_cpu_addr(cpu_addr), .i_opcode_fetch(opf), .i_instr_start(istart),
      .i_operand_fetch(operf), .i_instr_end(1'b0), .i_rti_exec(return_from_interrupt_op),
      .i_monitor_mode(mon), .i_wait_mode(wait_m), .i_stop_mode(1'b0),
      .i_high_test_voltage(htv), .o_rdata(rdata), .o_break(brk), .o_break_state(bstate),
      .o_timer_halt(thalt), .o_capture_block(cblock), .o_watchdog_stop(wdstop),
      .o_status_clear_ok(clr_ok), .o_wait_exited_by_break(wexit), .o_irq(irq));
   task automatic check(input logic [23:0] seen, input logic [23:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         errors++;
         $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr_reg(input logic [2:0] a, input logic [7:0] v);
      @(posedge i_clk);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge i_clk);
      wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [2:0] a, output logic [7:0] v);
      @(posedge i_clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge i_clk);
      rd <= 1'b0;
      #1 v = rdata;
   endtask
   task automatic run(input logic [15:0] b);
      @(posedge i_clk);
      base <= b;
      go <= 1'b1;
      @(posedge i_clk);
      go <= 1'b0;
      repeat (5) @(posedge i_clk);
      #1;
   endtask
   task automatic end_break();
      wr_reg(`ABU_OFF_CTRL, 8'h80);
      @(posedge i_clk);
      return_from_interrupt_op <= 1'b1;
      @(posedge i_clk);
      return_from_interrupt_op <= 1'b0;
      repeat (2) @(posedge i_clk);
      #1 check(bstate, 1'b0);
   endtask
   task automatic t_reset_and_disabled();
      for (int a = 0; a < 8; a++)
      begin
         rd_reg(a[2:0], d);
         check(d, `ABU_RST_BYTE);
      end
      wr_reg(`ABU_OFF_ADDR_HI, 8'h12);
      wr_reg(`ABU_OFF_ADDR_LO, 8'h34);
      rd_reg(`ABU_OFF_ADDR_HI, d);
      check(d, 8'h12);
      rd_reg(`ABU_OFF_ADDR_LO, d);
      check(d, 8'h34);
      run(16'h1234);
      check(reqs, 0);
   endtask
   task automatic t_opcode_match();
      wr_reg(`ABU_OFF_CTRL, 8'h80);
      run(16'h1234);
      check(reqs, 1);
      check(last_brk, {1'b1, `ABU_SWI_OPCODE, `ABU_VEC_NORMAL});
      check({bstate, thalt, cblock, wdstop, clr_ok}, 5'b11100);
      rd_reg(`ABU_OFF_CTRL, d);
      check(d, 8'hC0);
      rd_reg(`ABU_OFF_WAIT_STAT, d);
      check(d, 8'h00);
      wr_reg(`ABU_OFF_FLAG_CTRL, 8'h80);
      @(posedge i_clk);
      #1 check(clr_ok, 1'b1);
      wr_reg(`ABU_OFF_FLAG_CTRL, 8'h00);
      wr_reg(`ABU_OFF_IRQ_MASK, 8'h00);
      @(posedge i_clk);
      #1 irq_a = irq;
      wr_reg(`ABU_OFF_IRQ_MASK, 8'hFF);
      @(posedge i_clk);
      #1 check(irq ^ irq_a, 1'b1);
      rd_reg(`ABU_OFF_IRQ_STAT, d);
      check(d, 8'h01);
      rd_reg(`ABU_OFF_IRQ_STAT, d);
      check({d, irq}, 9'h000);
      end_break();
      run(16'h1234);
      check(reqs, 1);
   endtask
   task automatic t_operand_monitor();
      mon <= 1'b1;
      htv <= 1'b1;
      wr_reg(`ABU_OFF_ADDR_HI, 8'h20);
      wr_reg(`ABU_OFF_ADDR_LO, 8'h41);
      run(16'h2040);
      check(reqs, 2);
      check(last_brk.vector, `ABU_VEC_MONITOR);
      check(wdstop, 1'b1);
      end_break();
      mon <= 1'b0;
   endtask
   task automatic t_wait_soft();
      wait_m <= 1'b1;
      run(16'h2040);
      check(reqs, 2);
      wr_reg(`ABU_OFF_CTRL, 8'hC0);
      #1 check(reqs, 2);
      run(16'h3000);
      check(reqs, 3);
      check(last_brk, {1'b1, `ABU_SWI_OPCODE, `ABU_VEC_NORMAL});
      rd_reg(`ABU_OFF_WAIT_STAT, d);
      check(d, 8'h02);
      check(wexit, 1'b1);
      wait_m <= 1'b0;
      end_break();
      rd_reg(`ABU_OFF_IRQ_STAT, d);
      check(d, 8'h03);
      wr_reg(`ABU_OFF_CTRL, 8'h00);
      rd_reg(`ABU_OFF_CTRL, d);
      check(d, 8'h00);
   endtask
   task automatic final_report();
      $display("comparisons %0d mismatches %0d", check_count, errors);
      if (errors == 0 && check_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   initial
   begin
      #20000;
      errors++;
      final_report();
   end
   initial
   begin
      repeat (12) @(posedge i_clk);
      i_rst_b <= 1'b1;
      t_reset_and_disabled();
      t_opcode_match();
      t_operand_monitor();
      t_wait_soft();
      final_report();
   end
endmodule
